// File: bench/mie_core_chk.sv
// mie_core_chk: bus and halt assertions on the ports of mie_core.
// assumes: bound into mie_core; single clock aclk, sync active-low aresetn.
`timescale 1ns/10ps
module mie_core_chk
  import mie_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sys_clk_en_q
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_b_soon;
    ##[1:2] s_axi_bvalid;
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  AST_R_ANSWER: assert property ($rose(s_axi_arready) |-> s_axi_rvalid)
    else $error("read data not with arready");
  AST_AR_PULSE: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready longer than one cycle");
  AST_B_ANSWER: assert property (s_wr_both |-> s_b_soon)
    else $error("write answer late");
  AST_SLVERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == MIE_RESP_SLVERR
    |-> s_axi_rdata == 32'h0) else $error("refused read returns data");
  AST_READY_UP: assert property ($rose(aresetn) |-> ##[0:1] (s_axi_awready && s_axi_wready))
    else $error("write channel not ready after reset");
  AST_HALT_HOLD: assert property (
    !sys_clk_en_q && !s_axi_wvalid && !$past(s_axi_wvalid) |=> !sys_clk_en_q)
    else $error("clock restarted without a write");
endmodule : mie_core_chk

bind mie_core mie_core_chk u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sys_clk_en_q(sys_clk_en_q));

// File: bench/test_mie_core.sv
// test_mie_core: register-bus driven instruction tests for mie_core.
// assumes: mie_pkg register map; one write and one read at a time.
`timescale 1ns/10ps
module test_mie_core
  import mie_pkg::*;
;
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sys_clk_en_q;
  logic [31:0] v;
  logic [10:0] ep;
  logic eg, epd, eto;
  int err_total, checks;
  mie_core dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sys_clk_en_q(sys_clk_en_q));
  // ----------------------------------------
  // clock, checking and verdict
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic da, dw, db;
    da = 1'b0; dw = 1'b0; db = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wdata <= d; s_axi_wvalid <= 1'b1;
    s_axi_wstrb <= 4'hF; s_axi_bready <= 1'b1;
    while (!db) begin
      @(posedge aclk);
      if (!da && s_axi_awready) begin da = 1'b1; s_axi_awvalid <= 1'b0; end
      if (!dw && s_axi_wready) begin dw = 1'b1; s_axi_wvalid <= 1'b0; end
      if (s_axi_bvalid) begin db = 1'b1; r = s_axi_bresp; s_axi_bready <= 1'b0; end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic dr;
    dr = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    while (!dr) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin dr = 1'b1; d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 1'b0; end
    end
  endtask : rd
  // run one instruction, then compare flags, acc, addressed byte and pc
  task automatic step(input logic [19:0] i, input logic [7:0] a, input logic [7:0] m,
      input logic [1:0] cz);
    wr(MIE_REG_INSN, {12'h000, i}, rs);
    do rd(MIE_REG_STATUS, v, rs); while (v[MIE_ST_BUSY] !== 1'b0);
    ep = (i[19:16] == 4'h7) ? i[10:0] : (i[19:16] == 4'hD) ? 11'h000
        : (i[19:8] == {4'hA, MIE_PCL_ADDR}) ? {ep[10:8], a} : ep + 11'h001;
    chk(v & 32'h0000003F, {26'h0, eg, epd, eto, 1'b0, cz});
    rd(MIE_REG_ACC, v, rs);
    chk(v, {24'h0, a});
    rd(MIE_REG_MEM + {2'b00, i[11:8], 2'b00}, v, rs);
    chk(v, {24'h0, m});
    rd(MIE_REG_PC, v, rs);
    chk(v, {21'h0, ep});
  endtask : step
  task automatic poke(input logic [3:0] k, input logic [7:0] d);
    wr(MIE_REG_MEM + {2'b00, k, 2'b00}, {24'h0, d}, rs);
  endtask : poke
  // ----------------------------------------
  // watchdog and main sequence
  // ----------------------------------------
  initial begin
    #(40 * 40000);
    err_total++;
    give_verdict();
  end
  initial begin
    aresetn = 1'b0; s_axi_awaddr = 8'h00; s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0; s_axi_wstrb = 4'h0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00; s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
    err_total = 0; checks = 0; ep = 11'h000; eg = 1'b0; epd = 1'b0; eto = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(MIE_REG_STATUS, v, rs); chk(v, 32'h0);
    chk({31'h0, sys_clk_en_q}, 32'h1);
    wr(8'h30, 32'h0000_00FF, rs); chk({30'h0, rs}, {30'h0, MIE_RESP_SLVERR});
    rd(8'h30, v, rs); chk({30'h0, rs}, {30'h0, MIE_RESP_SLVERR}); chk(v, 32'h0);
    rd(MIE_REG_CTRL, v, rs); chk({30'h0, rs}, {30'h0, MIE_RESP_SLVERR});
    $display("test reset and map done");
    poke(4'h1, 8'hFF); poke(4'h4, 8'h10); poke(4'h5, 8'h81);
    step(20'h9003C, 8'h3C, 8'h00, 2'h0);
    step(20'hA0200, 8'h3C, 8'h3C, 2'h0);
    step(20'h80100, 8'hFF, 8'hFF, 2'h0);
    step(20'h20200, 8'hFF, 8'hC3, 2'h0);
    step(20'h20201, 8'h3C, 8'hC3, 2'h0);
    step(20'h50101, 8'h00, 8'hFF, 2'h1);
    step(20'h50100, 8'h00, 8'h00, 2'h1);
    step(20'h40100, 8'h00, 8'hFF, 2'h0);
    step(20'h40101, 8'hFE, 8'hFF, 2'h0);
    step(20'h90000, 8'h00, 8'h00, 2'h0);
    step(20'hB0300, 8'h00, 8'h00, 2'h1);
    step(20'hB0081, 8'h81, 8'h00, 2'h0);
    step(20'hC0400, 8'h81, 8'h91, 2'h0);
    step(20'hE0501, 8'h03, 8'h81, 2'h0);
    step(20'hE0500, 8'h03, 8'h03, 2'h0);
    $display("test data operations done");
    step(20'h9009A, 8'h9A, 8'h00, 2'h0);
    step(20'h30600, 8'h9A, 8'h00, 2'h2);
    step(20'h90012, 8'h12, 8'h00, 2'h2);
    step(20'h30700, 8'h12, 8'h72, 2'h2);
    step(20'h70123, 8'h12, 8'hFF, 2'h2);
    step(20'h00000, 8'h12, 8'h00, 2'h2);
    step(20'hD0000, 8'h12, 8'h00, 2'h2);
    step(20'hD0156, 8'h56, 8'hFF, 2'h2);
    eg = 1'b1;
    step(20'hD0200, 8'h56, 8'hC3, 2'h2);
    step(20'hA0F00, 8'h56, 8'h56, 2'h2);
    $display("test adjust, jump and returns done");
    repeat (20) wr(MIE_REG_CTRL, 32'h0000_0002, rs);
    epd = 1'b1;
    step(20'h60000, 8'h56, 8'h00, 2'h2);
    chk({31'h0, sys_clk_en_q}, 32'h0);
    rd(MIE_REG_WDT, v, rs); chk(v & 32'h0000_0FFF, 32'h0);
    wr(MIE_REG_INSN, 32'h0009_0077, rs);
    repeat (12) @(posedge aclk);
    rd(MIE_REG_ACC, v, rs); chk(v, 32'h0000_0056);
    wr(MIE_REG_CTRL, 32'h0000_0001, rs);
    repeat (2) @(posedge aclk);
    chk({31'h0, sys_clk_en_q}, 32'h1);
    $display("test halt done");
    repeat (20) wr(MIE_REG_CTRL, 32'h0000_0002, rs);
    step(20'h10000, 8'h56, 8'h00, 2'h2);
    rd(MIE_REG_WDT, v, rs); chk(v & 32'h0000_0FFF, 32'h0000_0401);
    rd(MIE_REG_STATUS, v, rs); chk({31'h0, v[MIE_ST_PRE1]}, 32'h1);
    epd = 1'b0;
    step(20'h10001, 8'h56, 8'h00, 2'h2);
    rd(MIE_REG_WDT, v, rs); chk(v & 32'h0000_00FF, 32'h0);
    $display("test watchdog pre-clear done");
    give_verdict();
  end
endmodule : test_mie_core

// File: verilog/mie_core.sv
// mie_core: executes one instruction word at a time from an axi4-lite register port.
// assumes: single 25 MHz clock, synchronous active-low reset, one bus master.
//
// Function
// [RULE1] both watchdog pre-clears done: counter zero, timeout and power-down flags cleared
// [RULE2] one pre-clear alone only records itself; counter and flags unchanged
// [RULE3] memory invert stores ones' complement in memory, updates zero flag only
// [RULE4] invert-to-acc writes complement to accumulator, memory untouched, zero flag only
// [RULE5] decimal adjust adds 6 per nibble when over 9 or carry set
// [RULE6] decimal adjust result goes to memory; only carry may change
// [RULE7] decrement to memory or accumulator, zero flag only
// [RULE8] increment to memory or accumulator, zero flag only
// [RULE9] halt advances pc, stops execution, keeps ram and registers
// [RULE10] halt clears watchdog and prescaler, sets power-down, clears timeout
// [RULE11] jump loads pc from instruction, flags untouched
// [RULE12] immediate move loads accumulator, flags untouched
// [RULE13] moves between accumulator and memory copy unchanged, flags untouched
// [RULE14] no-op only increments pc
// [RULE15] or into accumulator with memory or immediate, zero flag only
// [RULE16] or into memory with accumulator, zero flag only
// [RULE17] return pops pc, two instruction cycles, flags untouched
// [RULE18] return-with-value pops pc and loads accumulator with immediate
// [RULE19] interrupt return pops pc and sets global interrupt enable
// [RULE20] rotate left in memory, bit 7 to bit 0, flags untouched
// [RULE21] rotate left into accumulator, memory unchanged
// [RULE22] writing the low pc byte adds one instruction cycle of four clocks
// [RULE23] zero flag set when stored result is zero, else cleared
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
module mie_core
  import mie_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic sys_clk_en_q
);
  // ---------------------------------------------
  // state
  // ---------------------------------------------
  mie_state_t state_q;
  logic [7:0] acc_q;
  logic [10:0] pc_q;
  logic [10:0] stack_q [MIE_STACK_DEPTH];
  logic [1:0] sp_q;
  logic [7:0] mem_q [MIE_MEM_DEPTH];
  logic zero_q, carry_q, half_nibble_carry_q;
  logic timeout_flag_q, power_down_flag_q, global_irq_enable_q;
  logic pre1_q, pre2_q;
  logic [7:0] watchdog_counter_q;
  logic [3:0] presc_q;
  logic [19:0] insn_q;
  logic [2:0] clk_cnt_q;
  logic [1:0] cyc_left_q;
  mie_op_t op;
  logic [7:0] m_addr;
  logic [7:0] mem_rd;
  logic [7:0] alu_res;
  logic alu_to_acc, alu_to_mem, alu_upd_z, alu_c;
  logic exec_go;
  logic cyc_end;
  logic pcl_write;

  function automatic mie_op_t mie_decode(input logic [3:0] code, input logic [15:0] sub);
    case (code)
      4'h0: mie_decode = MIE_NOP;
      4'h1: mie_decode = (sub[0]) ? MIE_PRECLR2 : MIE_PRECLR1;
      4'h2: mie_decode = (sub[0]) ? MIE_INV_ACC : MIE_INV;
      4'h3: mie_decode = MIE_DAA;
      4'h4: mie_decode = (sub[0]) ? MIE_DEC_ACC : MIE_DEC;
      4'h5: mie_decode = (sub[0]) ? MIE_INC_ACC : MIE_INC;
      4'h6: mie_decode = MIE_HALT;
      4'h7: mie_decode = MIE_JMP;
      4'h8: mie_decode = MIE_MOV_AM;
      4'h9: mie_decode = MIE_MOV_AX;
      4'hA: mie_decode = MIE_MOV_MA;
      4'hB: mie_decode = (sub[0]) ? MIE_OR_AX : MIE_OR_AM;
      4'hC: mie_decode = MIE_OR_MA;
      4'hD: mie_decode = (sub[MIE_M_LO+1]) ? MIE_INTERRUPT_RETURN : ((sub[MIE_M_LO]) ? MIE_RET_AX : MIE_RET);
      4'hE: mie_decode = (sub[0]) ? MIE_RL_ACC : MIE_RL;
      default: mie_decode = MIE_BAD;
    endcase
  endfunction : mie_decode

  function automatic logic mie_is_ret(input mie_op_t o);
    mie_is_ret = (o == MIE_RET) || (o == MIE_RET_AX) || (o == MIE_INTERRUPT_RETURN);
  endfunction : mie_is_ret

  assign op = mie_decode(insn_q[MIE_OP_HI:MIE_OP_LO], insn_q[MIE_M_HI:MIE_X_LO]);
  assign m_addr = insn_q[MIE_M_HI:MIE_M_LO];
  assign mem_rd = mem_q[m_addr[MIE_MEM_AW-1:0]];
  assign cyc_end = (clk_cnt_q == MIE_CLKS_PER_CYC - 3'h1);
  assign exec_go = (state_q == MIE_S_RUN) && cyc_end && (cyc_left_q == 2'h0);
  assign pcl_write = alu_to_mem && (m_addr == MIE_PCL_ADDR);

  mie_exec_alu u_alu (
    .op(op),
    .acc(acc_q),
    .mem(mem_rd),
    .imm(insn_q[MIE_X_HI:MIE_X_LO]),
    .c_in(carry_q),
    .ac_in(half_nibble_carry_q),
    .result(alu_res),
    .to_acc(alu_to_acc),
    .to_mem(alu_to_mem),
    .upd_z(alu_upd_z),
    .c_out(alu_c)
  );

  // ---------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------
  logic aw_hold_q, w_hold_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_fire;
  logic insn_load;
  logic [31:0] rd_word;
  assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign insn_load = wr_fire && (aw_addr_q == MIE_REG_INSN) && w_strb_q[0]
                     && (state_q == MIE_S_IDLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= MIE_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_hold_q && !s_axi_awready;
      s_axi_wready <= !w_hold_q && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_q == MIE_REG_CTRL || aw_addr_q == MIE_REG_INSN
                        || aw_addr_q[7:6] == MIE_REG_MEM[7:6])
                       ? MIE_RESP_OKAY : MIE_RESP_SLVERR;
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      MIE_REG_STATUS: begin
        rd_word[MIE_ST_Z] = zero_q;
        rd_word[MIE_ST_C] = carry_q;
        rd_word[MIE_ST_AC] = half_nibble_carry_q;
        rd_word[MIE_ST_TO] = timeout_flag_q;
        rd_word[MIE_ST_PDF] = power_down_flag_q;
        rd_word[MIE_ST_EMI] = global_irq_enable_q;
        rd_word[MIE_ST_HALT] = (state_q == MIE_S_HALTED);
        rd_word[MIE_ST_BUSY] = (state_q == MIE_S_RUN);
        rd_word[MIE_ST_PRE1] = pre1_q;
        rd_word[MIE_ST_PRE2] = pre2_q;
      end
      MIE_REG_INSN: rd_word = {12'h000, insn_q};
      MIE_REG_ACC: rd_word = {24'h00_0000, acc_q};
      MIE_REG_PC: rd_word = {21'h00_0000, pc_q};
      MIE_REG_WDT: rd_word = {20'h0_0000, presc_q, watchdog_counter_q};
      default: begin
        if (s_axi_araddr[7:6] == MIE_REG_MEM[7:6]) begin
          rd_word = {24'h00_0000, mem_q[s_axi_araddr[MIE_MEM_AW+1:2]]};
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= MIE_RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
      end else if (s_axi_arvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= (s_axi_araddr <= MIE_REG_WDT && s_axi_araddr[1:0] == 2'h0
                        && s_axi_araddr != MIE_REG_CTRL)
                       || (s_axi_araddr[7:6] == MIE_REG_MEM[7:6])
                       ? MIE_RESP_OKAY : MIE_RESP_SLVERR;
      end
    end
  end

  // ---------------------------------------------
  // sequencer and instruction cycle timing
  // ---------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= MIE_S_IDLE;
      clk_cnt_q <= 3'h0;
      cyc_left_q <= 2'h0;
      insn_q <= 20'h0_0000;
      sys_clk_en_q <= 1'b1;
    end else begin
      case (state_q)
        MIE_S_IDLE: begin
          clk_cnt_q <= 3'h0;
          if (insn_load) begin
            insn_q <= w_data_q[19:0];
            state_q <= MIE_S_RUN;
          end
        end
        MIE_S_RUN: begin
          clk_cnt_q <= cyc_end ? 3'h0 : clk_cnt_q + 3'h1;
          if (cyc_end && cyc_left_q != 2'h0) begin
            cyc_left_q <= cyc_left_q - 2'h1;
            if (cyc_left_q == 2'h1) begin
              state_q <= MIE_S_IDLE;
            end
          end else if (exec_go) begin
            if (op == MIE_HALT) begin
              state_q <= MIE_S_HALTED; // RULE9
              sys_clk_en_q <= 1'b0; // RULE9
            end else if (mie_is_ret(op) || pcl_write) begin
              cyc_left_q <= 2'h1; // RULE17 RULE22
            end else begin
              state_q <= MIE_S_IDLE;
            end
          end
        end
        MIE_S_HALTED: begin
          clk_cnt_q <= 3'h0;
          if (wr_fire && aw_addr_q == MIE_REG_CTRL && w_data_q[MIE_CT_WAKE]) begin
            state_q <= MIE_S_IDLE;
            sys_clk_en_q <= 1'b1;
          end
        end
        default: state_q <= MIE_S_IDLE;
      endcase
    end
  end

  // ---------------------------------------------
  // program counter and return stack
  // ---------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_q <= MIE_PC_RESET;
      sp_q <= 2'h0;
      for (int i = 0; i < MIE_STACK_DEPTH; i++) begin
        stack_q[i] <= MIE_PC_RESET;
      end
    end else if (exec_go) begin
      if (op == MIE_JMP) begin
        pc_q <= insn_q[10:0]; // RULE11
      end else if (mie_is_ret(op)) begin
        pc_q <= stack_q[sp_q - 2'h1]; // RULE17 RULE18 RULE19
        sp_q <= sp_q - 2'h1;
      end else if (pcl_write) begin
        pc_q <= {pc_q[10:8], alu_res}; // RULE22
      end else begin
        pc_q <= pc_q + 11'h001; // RULE9 RULE14
      end
    end
  end

  // ---------------------------------------------
  // accumulator, data memory and alu flags
  // ---------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_q <= MIE_BYTE_ZERO;
      zero_q <= 1'b0;
      carry_q <= 1'b0;
      half_nibble_carry_q <= 1'b0;
      global_irq_enable_q <= 1'b0;
      for (int i = 0; i < MIE_MEM_DEPTH; i++) begin
        mem_q[i] <= MIE_BYTE_ZERO;
      end
    end else if (exec_go) begin
      if (alu_to_acc) begin
        acc_q <= alu_res; // RULE4 RULE12 RULE15 RULE18 RULE21
      end
      if (alu_to_mem) begin
        mem_q[m_addr[MIE_MEM_AW-1:0]] <= alu_res; // RULE3 RULE16 RULE20
      end
      if (alu_upd_z) begin
        zero_q <= (alu_res == MIE_BYTE_ZERO); // RULE23
      end
      carry_q <= alu_c; // RULE6
      if (op == MIE_INTERRUPT_RETURN) begin
        global_irq_enable_q <= 1'b1; // RULE19
      end
    end else if (state_q == MIE_S_IDLE && wr_fire && aw_addr_q[7:6] == MIE_REG_MEM[7:6]
                 && w_strb_q[0]) begin
      mem_q[aw_addr_q[MIE_MEM_AW+1:2]] <= w_data_q[7:0];
    end
  end

  // ---------------------------------------------
  // watchdog, pre-clear pair and power flags
  // ---------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watchdog_counter_q <= MIE_WDT_RESET;
      presc_q <= 4'h0;
      pre1_q <= 1'b0;
      pre2_q <= 1'b0;
      timeout_flag_q <= 1'b0;
      power_down_flag_q <= 1'b0;
    end else if (exec_go && op == MIE_HALT) begin
      watchdog_counter_q <= MIE_WDT_RESET; // RULE10
      presc_q <= 4'h0; // RULE10
      power_down_flag_q <= 1'b1; // RULE10
      timeout_flag_q <= 1'b0; // RULE10
    end else if (exec_go && ((op == MIE_PRECLR1 && pre2_q) || (op == MIE_PRECLR2 && pre1_q))) begin
      watchdog_counter_q <= MIE_WDT_RESET; // RULE1
      presc_q <= 4'h0;
      timeout_flag_q <= 1'b0; // RULE1
      power_down_flag_q <= 1'b0; // RULE1
      pre1_q <= 1'b0;
      pre2_q <= 1'b0;
    end else if (exec_go && op == MIE_PRECLR1) begin
      pre1_q <= 1'b1; // RULE2
    end else if (exec_go && op == MIE_PRECLR2) begin
      pre2_q <= 1'b1; // RULE2
    end else if (state_q != MIE_S_HALTED && wr_fire && aw_addr_q == MIE_REG_CTRL
                 && w_data_q[MIE_CT_WDTTICK]) begin
      presc_q <= presc_q + 4'h1;
      if (presc_q == MIE_PRESC_MAX) begin
        watchdog_counter_q <= watchdog_counter_q + 8'h01;
        if (watchdog_counter_q == 8'hFF) begin
          timeout_flag_q <= 1'b1;
        end
      end
    end
  end
endmodule : mie_core

// File: verilog/mie_exec_alu.sv
// mie_exec_alu: combinational result and flag logic for one instruction.
// assumes: operands come from mie_core on the same clock.
`timescale 1ns/10ps
module mie_exec_alu
  import mie_pkg::*;
(
  input wire mie_op_t op,
  input wire logic [7:0] acc,
  input wire logic [7:0] mem,
  input wire logic [7:0] imm,
  input wire logic c_in,
  input wire logic ac_in,
  output logic [7:0] result,
  output logic to_acc,
  output logic to_mem,
  output logic upd_z,
  output logic c_out
);
  logic [4:0] lo_sum;
  logic [4:0] hi_sum;
  logic bcd_low_nibble_overflow;
  // ---------------------------------------------
  // result select
  // ---------------------------------------------
  always_comb begin
    result = acc;
    to_acc = 1'b0;
    to_mem = 1'b0;
    upd_z = 1'b0;
    c_out = c_in;
    lo_sum = {1'b0, acc[3:0]};
    hi_sum = {1'b0, acc[7:4]};
    bcd_low_nibble_overflow = 1'b0;
    case (op)
      MIE_INV: begin
        result = ~mem; // RULE3
        to_mem = 1'b1;
        upd_z = 1'b1;
      end
      MIE_INV_ACC: begin
        result = ~mem; // RULE4
        to_acc = 1'b1;
        upd_z = 1'b1;
      end
      MIE_DAA: begin
        if (({1'b0, acc[3:0]} > MIE_BCD_MAX) || ac_in) begin
          lo_sum = {1'b0, acc[3:0]} + {1'b0, MIE_BCD_ADJ}; // RULE5
          bcd_low_nibble_overflow = lo_sum[4];
        end
        hi_sum = {1'b0, acc[7:4]} + {4'h0, bcd_low_nibble_overflow};
        if ((hi_sum > MIE_BCD_MAX) || c_in) begin
          hi_sum = hi_sum + {1'b0, MIE_BCD_ADJ}; // RULE5
          c_out = 1'b1;
        end
        result = {hi_sum[3:0], lo_sum[3:0]};
        to_mem = 1'b1; // RULE6
      end
      MIE_DEC, MIE_DEC_ACC: begin
        result = mem - 8'h01; // RULE7
        to_mem = (op == MIE_DEC);
        to_acc = (op == MIE_DEC_ACC);
        upd_z = 1'b1;
      end
      MIE_INC, MIE_INC_ACC: begin
        result = mem + 8'h01; // RULE8
        to_mem = (op == MIE_INC);
        to_acc = (op == MIE_INC_ACC);
        upd_z = 1'b1;
      end
      MIE_MOV_AX, MIE_RET_AX: begin
        result = imm; // RULE12 RULE18
        to_acc = 1'b1;
      end
      MIE_MOV_AM: begin
        result = mem; // RULE13
        to_acc = 1'b1;
      end
      MIE_MOV_MA: begin
        result = acc; // RULE13
        to_mem = 1'b1;
      end
      MIE_OR_AM, MIE_OR_AX: begin
        result = acc | ((op == MIE_OR_AM) ? mem : imm); // RULE15
        to_acc = 1'b1;
        upd_z = 1'b1;
      end
      MIE_OR_MA: begin
        result = acc | mem; // RULE16
        to_mem = 1'b1;
        upd_z = 1'b1;
      end
      MIE_RL, MIE_RL_ACC: begin
        result = {mem[6:0], mem[7]}; // RULE20 RULE21
        to_mem = (op == MIE_RL);
        to_acc = (op == MIE_RL_ACC);
      end
      default: begin
        result = acc;
      end
    endcase
  end
endmodule : mie_exec_alu

// File: verilog/mie_pkg.sv
// mie_pkg: constants, opcodes, register map and states for the execution core.
// assumes: imported by mie_core and mie_exec_alu.
package mie_pkg;
  // axi4-lite register byte offsets
  localparam logic [7:0] MIE_REG_CTRL = 8'h00;
  localparam logic [7:0] MIE_REG_INSN = 8'h04;
  localparam logic [7:0] MIE_REG_STATUS = 8'h08;
  localparam logic [7:0] MIE_REG_ACC = 8'h0C;
  localparam logic [7:0] MIE_REG_PC = 8'h10;
  localparam logic [7:0] MIE_REG_WDT = 8'h14;
  localparam logic [7:0] MIE_REG_MEM = 8'h40;
  localparam int MIE_MEM_DEPTH = 16;
  localparam int MIE_MEM_AW = 4;
  localparam int MIE_STACK_DEPTH = 4;
  localparam logic [1:0] MIE_RESP_OKAY = 2'h0;
  localparam logic [1:0] MIE_RESP_SLVERR = 2'h2;
  // status bit positions
  localparam int MIE_ST_Z = 0;
  localparam int MIE_ST_C = 1;
  localparam int MIE_ST_AC = 2;
  localparam int MIE_ST_TO = 3;
  localparam int MIE_ST_PDF = 4;
  localparam int MIE_ST_EMI = 5;
  localparam int MIE_ST_HALT = 6;
  localparam int MIE_ST_BUSY = 7;
  localparam int MIE_ST_PRE1 = 8;
  localparam int MIE_ST_PRE2 = 9;
  // ctrl bits
  localparam int MIE_CT_WAKE = 0;
  localparam int MIE_CT_WDTTICK = 1;
  // instruction word fields: [19:16] opcode, [15:8] operand/addr, [7:0] immediate
  localparam int MIE_OP_HI = 19;
  localparam int MIE_OP_LO = 16;
  localparam int MIE_M_HI = 15;
  localparam int MIE_M_LO = 8;
  localparam int MIE_X_HI = 7;
  localparam int MIE_X_LO = 0;
  localparam logic [10:0] MIE_PC_RESET = 11'h000;
  localparam logic [7:0] MIE_PCL_ADDR = 8'h0F;
  localparam logic [7:0] MIE_BYTE_ZERO = 8'h00;
  localparam logic [3:0] MIE_BCD_ADJ = 4'h6;
  localparam logic [4:0] MIE_BCD_MAX = 5'h09;
  localparam logic [7:0] MIE_WDT_RESET = 8'h00;
  localparam logic [3:0] MIE_PRESC_MAX = 4'hF;
  localparam logic [2:0] MIE_CLKS_PER_CYC = 3'h4;
  typedef enum logic [4:0] {
    MIE_NOP, MIE_PRECLR1, MIE_PRECLR2, MIE_INV, MIE_INV_ACC, MIE_DAA,
    MIE_DEC, MIE_DEC_ACC, MIE_INC, MIE_INC_ACC, MIE_HALT, MIE_JMP,
    MIE_MOV_AM, MIE_MOV_AX, MIE_MOV_MA, MIE_OR_AM, MIE_OR_AX, MIE_OR_MA,
    MIE_RET, MIE_RET_AX, MIE_INTERRUPT_RETURN, MIE_RL, MIE_RL_ACC, MIE_BAD
  } mie_op_t;
  typedef enum logic [1:0] {MIE_S_IDLE, MIE_S_RUN, MIE_S_HALTED} mie_state_t;
endpackage : mie_pkg
